// >>> inc/ca_decode_pkg.sv
package ca_decode_pkg;
  // address field positions
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned COL_W = 10;
  localparam int unsigned AP_BIT = 10;
  localparam int unsigned BC_BIT = 12;
  localparam int unsigned ROW_LOW_W = 14;
  localparam int unsigned BA_W = 2;
  localparam int unsigned BG_W = 2;
  localparam int unsigned MR_W = 4;
  // decoded command codes
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_ACT = 3'h1;
  localparam logic [2:0] CMD_RD = 3'h2;
  localparam logic [2:0] CMD_WR = 3'h3;
  localparam logic [2:0] CMD_PRE = 3'h4;
  localparam logic [2:0] CMD_MRS = 3'h5;
  localparam logic [2:0] CMD_OTHER = 3'h6;
  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
endpackage

// >>> logic/ca_pin_decode.sv
`timescale 1ns/1ps
// Contract
// RL1 - activate takes row, read/write takes column
// RL2 - mode register set takes opcode from address
// RL3 - read/write address bit 10 selects auto-precharge
// RL4 - precharge bit 10 low one, high all
// RL5 - single precharge bank from group and bank
// RL6 - address bit 12 low requests burst chop
// RL7 - activate when act and select low
// RL8 - during activate command pins are rows 16-14
// RL9 - act high: command pins encode commands
// RL10 - bank inputs pick bank or register
// RL11 - group inputs pick group or register
// RL12 - sixteen-bit mode ignores upper group input
// RL13 - select high means deselect, inputs ignored
module ca_pin_decode (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic cs_n_i,
  input wire logic act_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [17:0] addr_i,
  input wire logic [1:0] ba_i,
  input wire logic [1:0] bg_i,
  input wire logic x16_mode_i,
  output logic cmd_valid_o,
  output logic [2:0] cmd_o,
  output logic [17:0] row_o,
  output logic [9:0] col_o,
  output logic [17:0] opcode_o,
  output logic [1:0] bank_o,
  output logic [1:0] group_o,
  output logic [3:0] mr_sel_o,
  output logic auto_pre_o,
  output logic pre_all_o,
  output logic chop_o
);

  // ==========================================
  // pin synchronisers
  // pins are asynchronous to mclk; two stages before any decode
  // pins sampled as one word; controller holds them steady between edges
  localparam int unsigned SW = 28;
  // all ones reads as deselect, so nothing decodes straight out of reset
  localparam logic [SW-1:0] SYNC_IDLE = 28'hFFFFFFF;
  logic [SW-1:0] meta_reg;
  logic [SW-1:0] meta_next;
  logic [SW-1:0] sync_reg;
  logic [SW-1:0] sync_next;
  logic [SW-1:0] pins;

  assign pins = {
    x16_mode_i,
    cs_n_i,
    act_n_i,
    ras_n_i,
    cas_n_i,
    we_n_i,
    addr_i,
    ba_i,
    bg_i
  };

  always_comb begin
    meta_next = pins;
    sync_next = meta_reg;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= SYNC_IDLE;
      sync_reg <= SYNC_IDLE;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  logic s_x16;
  logic s_cs_n;
  logic s_act_n;
  logic s_ras_n;
  logic s_cas_n;
  logic s_we_n;
  logic [17:0] s_addr;
  logic [1:0] s_ba;
  logic [1:0] s_bg;

  assign s_x16 = sync_reg[27];
  assign s_cs_n = sync_reg[26];
  assign s_act_n = sync_reg[25];
  assign s_ras_n = sync_reg[24];
  assign s_cas_n = sync_reg[23];
  assign s_we_n = sync_reg[22];
  assign s_addr = sync_reg[21:4];
  assign s_ba = sync_reg[3:2];
  assign s_bg = sync_reg[1:0];

  // ==========================================
  // command decode
  logic cmd_valid_reg, cmd_valid_next;
  logic [2:0] cmd_reg, cmd_next;
  logic [17:0] row_reg, row_next;
  logic [9:0] col_reg, col_next;
  logic [17:0] opcode_reg, opcode_next;
  logic [1:0] bank_reg, bank_next;
  logic [1:0] group_reg, group_next;
  logic [3:0] mr_sel_reg, mr_sel_next;
  logic auto_pre_reg, auto_pre_next;
  logic pre_all_reg, pre_all_next;
  logic chop_reg, chop_next;
  logic [1:0] eff_bg;

  always_comb begin
    // upper group input unused in the wide part
    eff_bg = s_x16 ? {1'b0, s_bg[0]} : s_bg; // RL12
    cmd_valid_next = 1'b0;
    cmd_next = ca_decode_pkg::CMD_NONE;
    // held fields keep their value until a command updates them
    row_next = row_reg;
    col_next = col_reg;
    opcode_next = opcode_reg;
    bank_next = bank_reg;
    group_next = group_reg;
    mr_sel_next = mr_sel_reg;
    auto_pre_next = 1'b0;
    pre_all_next = 1'b0;
    chop_next = 1'b0;
    if (s_cs_n) begin
      // deselect: held fields keep their value, strobe, command and flags clear
      cmd_valid_next = 1'b0; // RL13
    end else if (!s_act_n) begin
      cmd_valid_next = 1'b1;
      cmd_next = ca_decode_pkg::CMD_ACT; // RL7
      // high row bits ride on the command pins
      row_next = {s_addr[17], s_ras_n, s_cas_n, s_we_n, s_addr[13:0]}; // RL8 RL1
      group_next = eff_bg; // RL11
      bank_next = s_ba; // RL10
    end else begin
      cmd_valid_next = 1'b1;
      // act high: pins are command encodings
      case ({s_ras_n, s_cas_n, s_we_n}) // RL9
        3'b000: begin
          cmd_next = ca_decode_pkg::CMD_MRS;
          opcode_next = s_addr; // RL2
          mr_sel_next = {eff_bg, s_ba}; // RL10 RL11
        end

        3'b010: begin
          // all-bank close still reports bank and group
          cmd_next = ca_decode_pkg::CMD_PRE;
          pre_all_next = s_addr[ca_decode_pkg::AP_BIT]; // RL4
          bank_next = s_ba; // RL5
          group_next = eff_bg; // RL5
        end

        3'b101: begin
          cmd_next = ca_decode_pkg::CMD_RD;
          col_next = s_addr[9:0]; // RL1
          auto_pre_next = s_addr[ca_decode_pkg::AP_BIT]; // RL3
          chop_next = !s_addr[ca_decode_pkg::BC_BIT]; // RL6
          bank_next = s_ba; // RL10
          group_next = eff_bg; // RL11
        end

        3'b100: begin
          cmd_next = ca_decode_pkg::CMD_WR;
          col_next = s_addr[9:0]; // RL1
          auto_pre_next = s_addr[ca_decode_pkg::AP_BIT]; // RL3
          chop_next = !s_addr[ca_decode_pkg::BC_BIT]; // RL6
          bank_next = s_ba; // RL10
          group_next = eff_bg; // RL11
        end

        default: begin
          // remaining encodings raise the strobe and report CMD_OTHER
          cmd_next = ca_decode_pkg::CMD_OTHER;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_valid_reg <= 1'b0;
      cmd_reg <= ca_decode_pkg::CMD_NONE;
      row_reg <= ca_decode_pkg::ADDR_RST;
      col_reg <= 10'h000;
      opcode_reg <= ca_decode_pkg::ADDR_RST;
      bank_reg <= 2'h0;
      group_reg <= 2'h0;
      mr_sel_reg <= 4'h0;
      auto_pre_reg <= 1'b0;
      pre_all_reg <= 1'b0;
      chop_reg <= 1'b0;
    end else begin
      cmd_valid_reg <= cmd_valid_next;
      cmd_reg <= cmd_next;
      row_reg <= row_next;
      col_reg <= col_next;
      opcode_reg <= opcode_next;
      bank_reg <= bank_next;
      group_reg <= group_next;
      mr_sel_reg <= mr_sel_next;
      auto_pre_reg <= auto_pre_next;
      pre_all_reg <= pre_all_next;
      chop_reg <= chop_next;
    end
  end

  // ==========================================
  // outputs, each straight from its register
  assign cmd_valid_o = cmd_valid_reg;
  assign cmd_o = cmd_reg;
  assign row_o = row_reg;
  assign col_o = col_reg;
  assign opcode_o = opcode_reg;
  assign bank_o = bank_reg;
  assign group_o = group_reg;
  assign mr_sel_o = mr_sel_reg;
  assign auto_pre_o = auto_pre_reg;
  assign pre_all_o = pre_all_reg;
  assign chop_o = chop_reg;

endmodule // ca_pin_decode

// >>> bench/ca_pin_decode_assertions.sv
`timescale 1ns/1ps
// ====================
// decode checker, outputs trail pins by three edges
module ca_pin_decode_checker (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic cs_n_i,
  input wire logic act_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic x16_mode_i,
  input wire logic cmd_valid_o,
  input wire logic auto_pre_o,
  input wire logic pre_all_o,
  input wire logic chop_o,
  input wire logic [17:0] addr_i,
  input wire logic [17:0] row_o,
  input wire logic [17:0] opcode_o,
  input wire logic [1:0] ba_i,
  input wire logic [1:0] bg_i,
  input wire logic [1:0] bank_o,
  input wire logic [1:0] group_o,
  input wire logic [2:0] cmd_o
);
  logic ac;
  logic [2:0] rcw;
  logic [1:0] warm_reg;
  logic [1:0] warm_next;
  assign ac = cs_n_i | act_n_i;
  assign rcw = {ras_n_i, cas_n_i, we_n_i};
  // three edges of history needed before $past is meaningful
  always_comb begin
    warm_next = (warm_reg == 2'h3) ? warm_reg : warm_reg + 2'h1;
  end
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      warm_reg <= 2'h0;
    end else begin
      warm_reg <= warm_next;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i || warm_reg != 2'h3);
  a_valid_sel: assert property (cmd_valid_o == !$past(cs_n_i, 3)) else $error("valid");
  a_act_seen: assert property (!$past(ac, 3) |-> cmd_o == 1) else $error("act");
  a_row_bits: assert property (cmd_o == 1 |-> row_o[16:14] == $past(rcw, 3)) else $error("row");
  a_rw_flags: assert property (cmd_o inside {2, 3} |->
    auto_pre_o == $past(addr_i[10], 3) && chop_o != $past(addr_i[12], 3)) else $error("rw");
  a_pre_scope: assert property (cmd_o == 4 |-> pre_all_o == $past(addr_i[10], 3)) else $error("pre");
  a_mrs_code: assert property (cmd_o == 5 |-> opcode_o == $past(addr_i, 3)) else $error("mrs");
  a_bank_pick: assert property (cmd_o inside {[1:4]} |->
    bank_o == $past(ba_i, 3) && group_o[0] == $past(bg_i[0], 3)) else $error("bank");
  a_upper_group: assert property (cmd_o == 1 && $past(x16_mode_i, 3) |-> !group_o[1]) else $error("bg");
  c_act: cover property (cmd_o == 1);
  c_pre_all: cover property (pre_all_o);
  c_chop: cover property (chop_o);
endmodule // ca_pin_decode_checker
bind ca_pin_decode ca_pin_decode_checker chk (.*);

// >>> bench/ca_ctrl_model.sv
`timescale 1ns/1ps
// ====================
// controller: op 0 deselects, address keeps moving
module ca_ctrl_model (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [2:0] op_i,
  input wire logic [17:0] a_i,
  output logic [22:0] pins_o = '1
);
  logic [2:0] enc [7] = '{7, 0, 5, 4, 2, 0, 7};
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) pins_o <= '1;
    else pins_o <= {op_i == 0, op_i != 1, op_i == 1 ? a_i[16:14] : enc[op_i], a_i};
  end
endmodule // ca_ctrl_model

// >>> bench/ddr4_cmd_addr_pin_decode_bench.sv
`timescale 1ns/1ps
// ====================
// random stream, model reads pins three edges back
module ddr4_cmd_addr_pin_decode_bench;
  logic mclk_i = 0, arst_n_i = 0, x16_mode_i = 0, cs_n_i, act_n_i, ras_n_i, cas_n_i, we_n_i;
  logic cmd_valid_o, auto_pre_o, pre_all_o, chop_o, rw;
  logic [2:0] op_i = 0, cmd_o, c, t [8] = '{5, 6, 4, 6, 3, 2, 6, 6};
  logic [17:0] a_i = 0, addr_i, row_o, opcode_o, er = 0, eo = 0;
  logic [1:0] ba_i = 0, bg_i = 0, bank_o, group_o, g, eb = 0, eg = 0;
  logic [9:0] col_o, ec = 0;
  logic [3:0] mr_sel_o, em = 0;
  logic [22:0] pins_o;
  logic [27:0] s, q[$] = '{'1, '1, '1};
  int error_cnt = 0, checked = 0;
  assign {cs_n_i, act_n_i, ras_n_i, cas_n_i, we_n_i, addr_i} = pins_o;
  ca_ctrl_model ctrl (.*);
  ca_pin_decode DUT (.*);
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  task automatic chk(logic [63:0] seen, logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED outputs expected %h seen %h", exp, seen);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ====================
  // model; reads before this edge's updates land
  always @(posedge mclk_i) if (arst_n_i) begin
    q.push_back({x16_mode_i, bg_i, ba_i, pins_o});
    s = q.pop_front();
    c = s[22] ? 3'h0 : s[21] ? t[s[20:18]] : 3'h1;
    g = s[27] ? {1'b0, s[25]} : s[26:25];
    rw = c == 2 || c == 3;
    if (c == 1) er = {s[17], s[20:18], s[13:0]};
    if (rw) ec = s[9:0];
    if (c == 5) {eo, em} = {s[17:0], g, s[24:23]};
    if (c != 0 && c < 5) {eb, eg} = {s[24:23], g};
    chk({cmd_valid_o, cmd_o, row_o, col_o, opcode_o, bank_o, group_o, mr_sel_o, auto_pre_o, pre_all_o, chop_o},
      {!s[22], c, er, ec, eo, eb, eg, em, rw & s[10], c == 4 & s[10], rw & !s[12]});
  end
  initial begin
    void'($urandom(32'h1256));
    repeat (3) @(posedge mclk_i);
    arst_n_i <= 1;
    repeat (3000) begin
      @(posedge mclk_i);
      op_i <= 3'($urandom % 7);
      {x16_mode_i, bg_i, ba_i, a_i} <= 23'($urandom);
    end
    repeat (4) @(posedge mclk_i);
    conclude();
  end
endmodule // ddr4_cmd_addr_pin_decode_bench
